// *** cra_pkg.sv ***
// Behaviour
// - shift left: zero in, carry from bit7
// - rotate left through carry into bit0
// - shift right: zero in, carry from bit0
// - rotate right through carry into bit7
// - arithmetic right keeps sign, carry bit0
// - memory forms read source from memory
// - ones complement touches only zero flag
// - twos complement: carry set when zero
// - chained complement: carry if zero and carry
// - increment: carry set on wrap to zero
// - increment by carry: carry if zero and carry
// - decrement: carry cleared on all ones
// - decrement by borrow: clear on ff, no carry
// - logic ops update only zero, accumulator and reg1
// - immediate logic forms use instruction byte
// - add: carry set on unsigned overflow
// - add with carry for multibyte sums
// - reverse subtract immediate: carry is not-borrow
// - two register reverse subtract into first
// - reverse subtract with borrow term
// - zero flag when result is zero
// - overflow flag on signed overflow
package cra_pkg;

    // ==========================================
    // widths and reset values
    localparam int DW = 8;
    localparam int RAW = 4;
    localparam int EAW = 16;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] ONES = 8'hff;
    localparam logic [7:0] NONE = 8'h00;

    // ==========================================
    // operation codes
    typedef enum logic [4:0] {
        OP_SHL, OP_SHLC, OP_SHR, OP_SHRC, OP_SHRA,
        OP_ONES_COMPLEMENT_OP, OP_TWOS_COMPLEMENT_OP, OP_TWOS_COMPLEMENT_CHAINED,
        OP_INC, OP_INCC, OP_DEC, OP_DECC,
        OP_AND, OP_OR, OP_XOR,
        OP_ADD, OP_ADDC, OP_SUBD, OP_SUBDC
    } cra_op_t;

    // operand forms
    typedef enum logic [2:0] {
        FM_REG1,  // reg
        FM_REG2,  // reg1, reg2
        FM_REG3,  // reg1, reg2, reg3
        FM_IMM,   // reg, #data
        FM_MEM    // reg, eaddr
    } cra_form_t;

    // sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} cra_state_t;

    // one instruction for the datapath
    typedef struct packed {
        cra_op_t op;
        cra_form_t form;
        logic [RAW-1:0] rd;
        logic [RAW-1:0] rs;
        logic [RAW-1:0] rt;
        logic [DW-1:0] imm;
        logic [EAW-1:0] eaddr;
    } cra_cmd_t;

    // condition flags
    typedef struct packed {
        logic c;
        logic v;
        logic z;
    } cra_flags_t;

    // 8-bit add, returns {carry, signed overflow, sum}
    function automatic logic [9:0] add8(input logic [7:0] p, input logic [7:0] q,
                                        input logic cin);
        logic [8:0] s;
        logic v;
        s = {1'b0, p} + {1'b0, q} + {8'h00, cin};
        v = (p[7] == q[7]) && (s[7] != p[7]);
        return {s[8], v, s[7:0]};
    endfunction

endpackage

// *** cra_regfile.sv ***
`timescale 1ns/1ps
// ==========================================
// register file: two registered read ports, one write port
module cra_regfile (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // read ports
    input wire logic [cra_pkg::RAW-1:0] ra_i,
    input wire logic [cra_pkg::RAW-1:0] rb_i,
    output logic [cra_pkg::DW-1:0] da_o,
    output logic [cra_pkg::DW-1:0] db_o,
    // write port
    input wire logic we_i,
    input wire logic [cra_pkg::RAW-1:0] wa_i,
    input wire logic [cra_pkg::DW-1:0] wd_i
);
    // storage, no reset: contents are software state
    logic [cra_pkg::DW-1:0] mem [2**cra_pkg::RAW];

    // write
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[wa_i] <= wd_i;
        end
    end

    // registered reads
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            da_o <= cra_pkg::NONE;
            db_o <= cra_pkg::NONE;
        end else begin
            da_o <= mem[ra_i];
            db_o <= mem[rb_i];
        end
    end
endmodule

// *** cra_shift.sv ***
`timescale 1ns/1ps
// ==========================================
// one-bit shifter and rotator
module cra_shift (
    // operation and data
    input wire cra_pkg::cra_op_t op_i,
    input wire logic [7:0] src_i,
    input wire logic cin_i,
    // result
    output logic [7:0] res_o,
    output logic cout_o,
    output logic ovf_o
);
    // shift network
    always_comb begin
        res_o = src_i;
        cout_o = cin_i;
        case (op_i)
            cra_pkg::OP_SHL: begin
                res_o = {src_i[6:0], 1'b0};
                cout_o = src_i[7];
            end
            cra_pkg::OP_SHLC: begin
                res_o = {src_i[6:0], cin_i};
                cout_o = src_i[7];
            end
            cra_pkg::OP_SHR: begin
                res_o = {1'b0, src_i[7:1]};
                cout_o = src_i[0];
            end
            cra_pkg::OP_SHRC: begin
                res_o = {cin_i, src_i[7:1]};
                cout_o = src_i[0];
            end
            cra_pkg::OP_SHRA: begin
                res_o = {src_i[7], src_i[7:1]};
                cout_o = src_i[0];
            end
            default: begin
                res_o = src_i;
                cout_o = cin_i;
            end
        endcase
        // signed overflow: the sign bit changed
        ovf_o = src_i[7] ^ res_o[7];
    end
endmodule

// *** cra_alu.sv ***
`timescale 1ns/1ps
// ==========================================
// 8-bit arithmetic and logic datapath
module cra_alu (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // instruction request
    input wire logic req_valid_i,
    input wire cra_pkg::cra_cmd_t req_cmd_i,
    output logic req_ready_o,
    // data memory read
    output logic dm_rd_o,
    output logic [cra_pkg::EAW-1:0] dm_addr_o,
    input wire logic [cra_pkg::DW-1:0] dm_data_i,
    // results
    output logic done_o,
    output logic [cra_pkg::DW-1:0] acc_o,
    output cra_pkg::cra_flags_t flags_o
);

    // ==========================================
    // state
    cra_pkg::cra_state_t state_q;  // sequencer
    cra_pkg::cra_cmd_t cmd_q;      // latched instruction
    cra_pkg::cra_flags_t flags_q;  // c, v, z
    logic [7:0] acc_q;             // accumulator
    logic ready_q;                 // idle and able to take
    logic done_q;                  // result written pulse
    logic dm_rd_q;                 // memory read strobe
    logic [cra_pkg::EAW-1:0] dm_addr_q;
    logic accept;                  // request taken this cycle
    logic exec;                    // execute cycle

    assign accept = req_valid_i && ready_q;
    assign exec = (state_q == cra_pkg::ST_EXEC);

    // ==========================================
    // sequencer: take, fetch operands, execute
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= cra_pkg::ST_IDLE;
        end else begin
            case (state_q)
                cra_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_q <= cra_pkg::ST_FETCH;
                    end
                end
                cra_pkg::ST_FETCH: state_q <= cra_pkg::ST_EXEC;
                cra_pkg::ST_EXEC: state_q <= cra_pkg::ST_IDLE;
                default: state_q <= cra_pkg::ST_IDLE;
            endcase
        end
    end

    // ready falls on accept and rises after execute
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_q <= 1'b1;
        end else if (accept) begin
            ready_q <= 1'b0;
        end else if (exec) begin
            ready_q <= 1'b1;
        end
    end

    // instruction latch
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q <= '0;
        end else if (accept) begin
            cmd_q <= req_cmd_i;
        end
    end

    // ==========================================
    // data memory read for memory forms
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dm_rd_q <= 1'b0;
            dm_addr_q <= '0;
        end else begin
            dm_rd_q <= accept && (req_cmd_i.form == cra_pkg::FM_MEM);
            if (accept) begin
                dm_addr_q <= req_cmd_i.eaddr;
            end
        end
    end

    // ==========================================
    // register file, read addresses from the latched instruction
    logic [cra_pkg::RAW-1:0] ra;  // first read port
    logic [cra_pkg::RAW-1:0] rb;  // second read port
    logic [7:0] da;
    logic [7:0] db;
    logic [7:0] res_d;            // result to acc and reg

    // three register form reads reg2 and reg3, others reg1 and reg2
    assign ra = (cmd_q.form == cra_pkg::FM_REG3) ? cmd_q.rs : cmd_q.rd;
    assign rb = (cmd_q.form == cra_pkg::FM_REG3) ? cmd_q.rt : cmd_q.rs;

    cra_regfile u_regs (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ra_i(ra),
        .rb_i(rb),
        .da_o(da),
        .db_o(db),
        .we_i(exec),
        .wa_i(cmd_q.rd),
        .wd_i(res_d)
    );

    // ==========================================
    // operand selection
    logic [7:0] src;   // single operand source
    logic [7:0] x;     // first operand of two
    logic [7:0] y;     // second operand of two
    logic [7:0] mn;    // reverse subtract minuend
    logic [7:0] sb;    // reverse subtract subtrahend

    always_comb begin
        case (cmd_q.form)
            cra_pkg::FM_REG2: src = db;
            cra_pkg::FM_MEM: src = dm_data_i;
            default: src = da;
        endcase
        x = da;
        case (cmd_q.form)
            cra_pkg::FM_IMM: y = cmd_q.imm;
            cra_pkg::FM_MEM: y = dm_data_i;
            default: y = db;
        endcase
        // three register form subtracts reg3 from reg2, others reverse
        if (cmd_q.form == cra_pkg::FM_REG3) begin
            mn = x;
            sb = y;
        end else begin
            mn = y;
            sb = x;
        end
    end

    // ==========================================
    // compute
    logic [7:0] sh_res;
    logic sh_c;
    logic sh_v;
    logic [9:0] sum;   // {carry, overflow, result}
    logic use_sum;     // result and c, v from adder
    logic use_sh;      // result and c, v from shifter

    cra_shift u_shift (
        .op_i(cmd_q.op),
        .src_i(src),
        .cin_i(flags_q.c),
        .res_o(sh_res),
        .cout_o(sh_c),
        .ovf_o(sh_v)
    );

    always_comb begin
        sum = '0;
        use_sum = 1'b1;
        use_sh = 1'b0;
        res_d = acc_q;
        case (cmd_q.op)
            cra_pkg::OP_SHL, cra_pkg::OP_SHLC, cra_pkg::OP_SHR,
            cra_pkg::OP_SHRC, cra_pkg::OP_SHRA: begin
                use_sum = 1'b0;
                use_sh = 1'b1;
            end
            cra_pkg::OP_ONES_COMPLEMENT_OP: begin
                use_sum = 1'b0;
                res_d = ~src;
            end
            cra_pkg::OP_TWOS_COMPLEMENT_OP: sum = cra_pkg::add8(~src, cra_pkg::NONE, 1'b1);
            cra_pkg::OP_TWOS_COMPLEMENT_CHAINED: sum = cra_pkg::add8(~src, cra_pkg::NONE, flags_q.c);
            cra_pkg::OP_INC: sum = cra_pkg::add8(src, cra_pkg::NONE, 1'b1);
            cra_pkg::OP_INCC: sum = cra_pkg::add8(src, cra_pkg::NONE, flags_q.c);
            cra_pkg::OP_DEC: sum = cra_pkg::add8(src, cra_pkg::ONES, 1'b0);
            cra_pkg::OP_DECC: sum = cra_pkg::add8(src, cra_pkg::ONES, flags_q.c);
            cra_pkg::OP_AND: begin
                use_sum = 1'b0;
                res_d = x & y;
            end
            cra_pkg::OP_OR: begin
                use_sum = 1'b0;
                res_d = x | y;
            end
            cra_pkg::OP_XOR: begin
                use_sum = 1'b0;
                res_d = x ^ y;
            end
            cra_pkg::OP_ADD: sum = cra_pkg::add8(x, y, 1'b0);
            cra_pkg::OP_ADDC: sum = cra_pkg::add8(x, y, flags_q.c);
            // carry out of mn + ~sb + 1 is the inverted borrow
            cra_pkg::OP_SUBD: sum = cra_pkg::add8(mn, ~sb, 1'b1);
            cra_pkg::OP_SUBDC: sum = cra_pkg::add8(mn, ~sb, flags_q.c);
            default: use_sum = 1'b0;
        endcase
        if (use_sh) begin
            res_d = sh_res;
        end else if (use_sum) begin
            res_d = sum[7:0];
        end
    end

    // ==========================================
    // accumulator and flags, written in the execute cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= cra_pkg::ACC_RST;
            flags_q <= '0;
        end else if (exec) begin
            acc_q <= res_d;
            flags_q.z <= (res_d == cra_pkg::NONE);
            if (use_sh) begin
                flags_q.c <= sh_c;
                flags_q.v <= sh_v;
            end else if (use_sum) begin
                flags_q.c <= sum[9];
                flags_q.v <= sum[8];
            end
            // logic ops and ones complement keep c and v
        end
    end

    // completion pulse
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= exec;
        end
    end

    assign req_ready_o = ready_q;
    assign dm_rd_o = dm_rd_q;
    assign dm_addr_o = dm_addr_q;
    assign done_o = done_q;
    assign acc_o = acc_q;
    assign flags_o = flags_q;

    // ==========================================
    // checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic [8:0] add_ref;
    assign add_ref = {1'b0, x} + {1'b0, y};

    sequence s_take;
        req_valid_i && req_ready_o;
    endsequence
    sequence s_finish;
        !req_ready_o ##1 !req_ready_o ##1 done_o && req_ready_o;
    endsequence
    sequence s_op(cra_pkg::cra_op_t o);
        exec && cmd_q.op == o;
    endsequence

    req_done_a: assert property (s_take |=> s_finish)
        else $error("request did not complete in three cycles");
    shl_result_a: assert property (s_op(cra_pkg::OP_SHL) |=>
        acc_o == {$past(src[6:0]), 1'b0} && flags_o.c == $past(src[7]))
        else $error("shift left result or carry wrong");
    rlc_bit_a: assert property (s_op(cra_pkg::OP_SHLC) |=>
        acc_o[0] == $past(flags_q.c) && flags_o.c == $past(src[7]))
        else $error("rotate left carry in wrong");
    shr_result_a: assert property (s_op(cra_pkg::OP_SHR) |=>
        !acc_o[7] && flags_o.c == $past(src[0]))
        else $error("shift right msb or carry wrong");
    rrc_bit_a: assert property (s_op(cra_pkg::OP_SHRC) |=>
        acc_o[7] == $past(flags_q.c))
        else $error("rotate right carry in wrong");
    sra_sign_a: assert property (s_op(cra_pkg::OP_SHRA) |=>
        acc_o[7] == acc_o[6] && flags_o.c == $past(src[0]))
        else $error("arithmetic right sign lost");
    mem_read_a: assert property ((s_take and req_cmd_i.form == cra_pkg::FM_MEM) |=>
        dm_rd_o && dm_addr_o == $past(req_cmd_i.eaddr) ##1 !dm_rd_o)
        else $error("memory read strobe wrong");
    ones_complement_op_keep_a: assert property (s_op(cra_pkg::OP_ONES_COMPLEMENT_OP) |=>
        acc_o == ~$past(src) && $stable(flags_o.c) && $stable(flags_o.v))
        else $error("ones complement changed c or v");
    twos_complement_op_carry_a: assert property (s_op(cra_pkg::OP_TWOS_COMPLEMENT_OP) |=>
        flags_o.c == (acc_o == 8'h00))
        else $error("twos complement carry wrong");
    dec_carry_a: assert property (s_op(cra_pkg::OP_DEC) |=>
        flags_o.c == (acc_o != 8'hff))
        else $error("decrement carry wrong");
    logic_keep_a: assert property (exec && cmd_q.op inside {cra_pkg::OP_AND,
        cra_pkg::OP_OR, cra_pkg::OP_XOR} |=> $stable(flags_o.c) && $stable(flags_o.v))
        else $error("logic op changed c or v");
    add_carry_a: assert property (s_op(cra_pkg::OP_ADD) |=>
        {flags_o.c, acc_o} == $past(add_ref))
        else $error("add sum or carry wrong");
    subd_carry_a: assert property (s_op(cra_pkg::OP_SUBD) |=>
        flags_o.c == ($past(mn) >= $past(sb)) && acc_o == $past(mn) - $past(sb))
        else $error("reverse subtract wrong");
    zero_flag_a: assert property (done_o |-> flags_o.z == (acc_o == 8'h00))
        else $error("zero flag disagrees with accumulator");
endmodule

// *** cra_alu_test.sv ***
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the 8-bit datapath
module cra_alu_test;

    // ==========================================
    // design inputs and outputs
    logic sys_clk_i = 1'b0; // 100 MHz clock
    logic rst_i = 1'b1; // async reset, high
    logic req_valid_i = 1'b0; // request strobe
    cra_pkg::cra_cmd_t req_cmd_i = '0; // instruction
    logic [7:0] dm_data_i = 8'h00; // memory read data
    logic req_ready_o;
    logic dm_rd_o;
    logic done_o;
    logic [15:0] dm_addr_o;
    logic [7:0] acc_o;
    cra_pkg::cra_flags_t flags_o;

    // ==========================================
    // model state and bookkeeping
    logic [7:0] rg [16]; // register copy
    logic [7:0] macc; // expected accumulator
    logic mc = 1'b0; // expected carry
    logic mv = 1'b0; // expected overflow
    logic mz = 1'b0; // expected zero
    logic [7:0] mem_val = 8'h00; // byte the memory returns
    logic [15:0] mem_addr = 16'h0000; // address it answers
    cra_pkg::cra_op_t op;
    cra_pkg::cra_form_t fm;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;

    // ==========================================
    // design under test
    cra_alu i_dut (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .req_valid_i(req_valid_i),
        .req_cmd_i(req_cmd_i),
        .req_ready_o(req_ready_o),
        .dm_rd_o(dm_rd_o),
        .dm_addr_o(dm_addr_o),
        .dm_data_i(dm_data_i),
        .done_o(done_o),
        .acc_o(acc_o),
        .flags_o(flags_o)
    );

    // clock generator
    always #5 sys_clk_i = ~sys_clk_i;

    // data memory: answers one cycle after the strobe, scrambles otherwise
    always @(posedge sys_clk_i) begin
        if (dm_rd_o === 1'b1 && dm_addr_o === mem_addr) begin
            dm_data_i <= mem_val;
        end else begin
            dm_data_i <= ~dm_data_i;
        end
    end

    // hang guard: whole run needs about 1400 cycles
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ==========================================
    // compare tasks
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================
    // reference model
    function automatic logic [9:0] addm(input logic [7:0] p, q, input logic ci);
        logic [8:0] s;
        s = 9'(p) + 9'(q) + 9'(ci);
        return {s[8], (p[7] == q[7]) && (s[7] != p[7]), s[7:0]};
    endfunction

    task automatic model(input cra_pkg::cra_cmd_t k, input logic [7:0] m);
        logic [7:0] x, y, p, q;
        logic [9:0] s;
        logic un;
        un = k.op < cra_pkg::OP_AND;
        // pick operands per form
        case (k.form)
            cra_pkg::FM_REG1: begin x = rg[k.rd]; y = 8'h00; end
            cra_pkg::FM_REG2: begin x = un ? rg[k.rs] : rg[k.rd]; y = rg[k.rs]; end
            cra_pkg::FM_REG3: begin x = rg[k.rs]; y = rg[k.rt]; end
            cra_pkg::FM_IMM: begin x = rg[k.rd]; y = k.imm; end
            default: begin x = un ? m : rg[k.rd]; y = m; end
        endcase
        // reverse subtract takes the second operand first, the three-register form the first
        p = (k.form == cra_pkg::FM_REG3) ? x : y;
        q = (k.form == cra_pkg::FM_REG3) ? y : x;
        s = {mc, mv, 8'h00};
        case (k.op)
            cra_pkg::OP_SHL: s = {x[7], x[7] ^ x[6], x[6:0], 1'b0};
            cra_pkg::OP_SHLC: s = {x[7], x[7] ^ x[6], x[6:0], mc};
            cra_pkg::OP_SHR: s = {x[0], x[7], 1'b0, x[7:1]};
            cra_pkg::OP_SHRC: s = {x[0], x[7] ^ mc, mc, x[7:1]};
            cra_pkg::OP_SHRA: s = {x[0], 1'b0, x[7], x[7:1]};
            cra_pkg::OP_ONES_COMPLEMENT_OP: s[7:0] = ~x;
            cra_pkg::OP_TWOS_COMPLEMENT_OP: s = addm(~x, 8'h00, 1'b1);
            cra_pkg::OP_TWOS_COMPLEMENT_CHAINED: s = addm(~x, 8'h00, mc);
            cra_pkg::OP_INC: s = addm(x, 8'h00, 1'b1);
            cra_pkg::OP_INCC: s = addm(x, 8'h00, mc);
            cra_pkg::OP_DEC: s = addm(x, 8'hff, 1'b0);
            cra_pkg::OP_DECC: s = addm(x, 8'hff, mc);
            cra_pkg::OP_AND: s[7:0] = x & y;
            cra_pkg::OP_OR: s[7:0] = x | y;
            cra_pkg::OP_XOR: s[7:0] = x ^ y;
            cra_pkg::OP_ADD: s = addm(x, y, 1'b0);
            cra_pkg::OP_ADDC: s = addm(x, y, mc);
            cra_pkg::OP_SUBD: s = addm(p, ~q, 1'b1);
            default: s = addm(p, ~q, mc);
        endcase
        {mc, mv} = s[9:8];
        macc = s[7:0];
        mz = (macc == 8'h00);
        rg[k.rd] = macc;
    endtask

    // ==========================================
    // one instruction: issue, walk the cycles, compare the result
    task automatic run(input cra_pkg::cra_op_t o, input cra_pkg::cra_form_t f,
                       input logic [3:0] rd, rs, rt, input logic [7:0] imm, mb);
        cra_pkg::cra_cmd_t k;
        int n;
        logic mem;
        k = '{o, f, rd, rs, rt, imm, 16'($urandom)};
        mem = (f == cra_pkg::FM_MEM);
        n = 0;
        @(posedge sys_clk_i);
        mem_val <= mb;
        mem_addr <= k.eaddr;
        req_cmd_i <= k;
        req_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        // wait for the taking edge
        while (req_ready_o !== 1'b1 && n < 10) begin
            @(posedge sys_clk_i);
            n++;
        end
        req_valid_i <= 1'b0;
        model(k, mb);
        #1;
        chk_bits({req_ready_o, done_o, dm_rd_o}, {2'b00, mem});
        if (mem) chk_word(dm_addr_o, k.eaddr);
        @(posedge sys_clk_i);
        #1;
        chk_bits({req_ready_o, done_o, dm_rd_o}, 3'b000);
        @(posedge sys_clk_i);
        #1;
        chk_bits({req_ready_o, done_o, dm_rd_o}, 3'b110);
        chk_word(16'(acc_o), 16'(macc));
        chk_bits(flags_o, {mc, mv, mz});
    endtask

    // load a register through a memory-form complement
    task automatic ld(input logic [3:0] r, input logic [7:0] v);
        run(cra_pkg::OP_ONES_COMPLEMENT_OP, cra_pkg::FM_MEM, r, 4'h0, 4'h0, 8'h00, ~v);
    endtask

    // closing report
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h6732));
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        chk_bits({req_ready_o, done_o, dm_rd_o}, 3'b100);
        chk_word(16'(acc_o), 16'h0000);
        chk_bits(flags_o, 3'b000);
        // fill every register first
        for (int i = 0; i < 16; i++) begin
            ld(4'(i), 8'($urandom));
        end
        // shifts and rotates at the edge bits, then a ones complement
        ld(4'h1, 8'h81);
        run(cra_pkg::OP_SHL, cra_pkg::FM_REG1, 4'h1, 4'h0, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_SHLC, cra_pkg::FM_REG2, 4'h2, 4'h1, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_SHR, cra_pkg::FM_MEM, 4'h3, 4'h0, 4'h0, 8'h00, 8'h81);
        run(cra_pkg::OP_SHRC, cra_pkg::FM_REG1, 4'h2, 4'h0, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_SHRA, cra_pkg::FM_MEM, 4'h3, 4'h0, 4'h0, 8'h00, 8'h81);
        run(cra_pkg::OP_ONES_COMPLEMENT_OP, cra_pkg::FM_REG2, 4'h4, 4'h2, 4'h0, 8'h00, 8'h00);
        // complement, increment, decrement at the wrap points
        run(cra_pkg::OP_TWOS_COMPLEMENT_OP, cra_pkg::FM_MEM, 4'h4, 4'h0, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_TWOS_COMPLEMENT_CHAINED, cra_pkg::FM_MEM, 4'h4, 4'h0, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_INC, cra_pkg::FM_MEM, 4'h4, 4'h0, 4'h0, 8'h00, 8'hff);
        run(cra_pkg::OP_INCC, cra_pkg::FM_MEM, 4'h4, 4'h0, 4'h0, 8'h00, 8'hff);
        run(cra_pkg::OP_DEC, cra_pkg::FM_MEM, 4'h4, 4'h0, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_DECC, cra_pkg::FM_MEM, 4'h4, 4'h0, 4'h0, 8'h00, 8'h00);
        // logic operations in three-register and immediate forms
        for (int i = 0; i < 3; i++) begin
            op = cra_pkg::cra_op_t'(int'(cra_pkg::OP_AND) + i);
            run(op, cra_pkg::FM_REG3, 4'h5, 4'h9, 4'ha, 8'h00, 8'h00);
            run(op, cra_pkg::FM_IMM, 4'h5, 4'h0, 4'h0, 8'h3c, 8'h00);
        end
        // add and reverse subtract at the carry boundaries
        ld(4'h5, 8'h80);
        run(cra_pkg::OP_ADD, cra_pkg::FM_MEM, 4'h5, 4'h0, 4'h0, 8'h00, 8'h80);
        run(cra_pkg::OP_ADDC, cra_pkg::FM_IMM, 4'h5, 4'h0, 4'h0, 8'hff, 8'h00);
        ld(4'h6, 8'h01);
        run(cra_pkg::OP_SUBD, cra_pkg::FM_IMM, 4'h6, 4'h0, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_SUBD, cra_pkg::FM_REG2, 4'h6, 4'h7, 4'h0, 8'h00, 8'h00);
        run(cra_pkg::OP_SUBDC, cra_pkg::FM_REG3, 4'h8, 4'h6, 4'h7, 8'h00, 8'h00);
        // random operations over every code and form
        repeat (300) begin
            op = cra_pkg::cra_op_t'($urandom_range(18, 0));
            if (op < cra_pkg::OP_AND) begin
                fm = cra_pkg::cra_form_t'($urandom_range(2, 0));
                if (fm == cra_pkg::FM_REG3) fm = cra_pkg::FM_MEM;
            end else begin
                fm = cra_pkg::cra_form_t'($urandom_range(4, 1));
            end
            run(op, fm, 4'($urandom), 4'($urandom), 4'($urandom),
                8'($urandom), 8'($urandom));
        end
        print_verdict();
    end

endmodule
